// ===== src/pgpfc_pkg.sv
package pgpfc_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [31:0] ADDR_LATCH = 32'hffff_83ae;
  localparam logic [31:0] ADDR_DIR   = 32'hffff_83b0;
  localparam logic [31:0] ADDR_SELH  = 32'hffff_83b2;
  localparam logic [31:0] ADDR_SELL  = 32'hffff_83b4;

  // Writable masks and fixed-one read patterns
  localparam logic [15:0] SELH_WMASK = 16'hf555;
  localparam logic [15:0] SELH_ONES  = 16'h0aaa;
  localparam logic [15:0] SELL_WMASK = 16'h557f;
  localparam logic [15:0] SELL_ONES  = 16'haa80;
  localparam logic [15:0] RESET_ZERO = 16'h0000;

  // Field positions
  localparam int P15_SEL = 14;
  localparam int P14_SEL = 12;
  localparam int P13_SEL = 10;
  localparam int P12_SEL = 8;
  localparam int P11_SEL = 6;
  localparam int P10_SEL = 4;
  localparam int P9_SEL  = 2;
  localparam int P8_SEL  = 0;
  localparam int P7_SEL  = 14;
  localparam int P6_SEL  = 12;
  localparam int P5_SEL  = 10;
  localparam int P4_SEL  = 8;
  localparam int P3_SEL  = 6;
  localparam int P2_SEL  = 5;
  localparam int P1_SEL  = 4;
  localparam int P0_SEL  = 2;
  localparam int RQ_SRC  = 0;

  // Two-bit select codes
  localparam logic [1:0] SEL2_PLAIN = 2'h0;
  localparam logic [1:0] SEL2_ALT1  = 2'h1;
  localparam logic [1:0] SEL2_ALT2  = 2'h2;

  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } pgpfc_bus_s;

  typedef struct packed {
    logic [15:0] latch;
    logic [15:0] dir;
    logic [15:0] selh;
    logic [15:0] sell;
    logic [15:0] rdata;
  } pgpfc_state_s;

endpackage : pgpfc_pkg

// ===== src/pgpfc_sync.sv
`timescale 1ns/100ps
`default_nettype none
module pgpfc_sync #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         reset_n,
  // Data
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : pgpfc_sync
`default_nettype wire

// ===== src/pgpfc_top.sv
// Added by the designer: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module pgpfc_top (
  // Clock and reset
  input  wire logic                   clock,
  input  wire logic                   reset_n,
  // Register port
  input  wire pgpfc_pkg::pgpfc_bus_s  bus,
  output logic [15:0]                 rdata,
  // Pins
  input  wire logic [15:0]            pin_in,
  output logic [15:0]                 pin_out,
  output logic [15:0]                 pin_oe,
  // Timer capture/compare: 0..6 = b5,a5,d4,c4,b4,a4,d3
  input  wire logic [6:0]             timer_cc_out,
  input  wire logic [6:0]             timer_cc_oe,
  output logic [6:0]                  timer_cc_in,
  // Interrupt request inputs
  output logic                        ext_interrupt_in_5,
  output logic                        ext_interrupt_in_4,
  // Serial channels
  output logic                        serial2_rx,
  input  wire logic                   serial2_tx,
  output logic                        serial1_rx,
  input  wire logic                   serial1_tx,
  input  wire logic                   serial1_clk_out,
  input  wire logic                   serial1_clk_oe,
  output logic                        serial1_clk_in,
  output logic                        serial0_rx,
  input  wire logic                   serial0_tx,
  input  wire logic                   serial0_clk_out,
  input  wire logic                   serial0_clk_oe,
  output logic                        serial0_clk_in,
  // Conversion trigger and request output sources
  output logic                        conversion_trigger_in,
  input  wire logic                   interrupt_controller_request,
  input  wire logic                   refresh_request
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  pgpfc_pkg::pgpfc_state_s st_q;
  pgpfc_pkg::pgpfc_state_s st_d;
  logic [15:0]             pin_s;
  logic [15:0]             plain;
  logic [15:0]             selh_rd;
  logic [15:0]             sell_rd;
  logic [15:0]             port_rd;
  logic [1:0]              sel15;
  logic [1:0]              sel14;
  logic [1:0]              sel0;
  logic [1:0]              rqsrc;
  logic                    request_output_pin;

  function automatic logic [15:0] masked_write(input logic [15:0] old, input logic [15:0] val,
                                               input logic [15:0] mask);
    masked_write = (old & ~mask) | (val & mask);
  endfunction : masked_write

  // Pins cross from outside: two flops before use
  pgpfc_sync #(.W(16)) u_sync (
    .clock    (clock),
    .reset_n  (reset_n),
    .async_in (pin_in),
    .sync_out (pin_s)
  );

  assign sel15 = st_q.selh[pgpfc_pkg::P15_SEL +: 2];
  assign sel14 = st_q.selh[pgpfc_pkg::P14_SEL +: 2];
  assign sel0  = st_q.sell[pgpfc_pkg::P0_SEL +: 2];
  assign rqsrc = st_q.sell[pgpfc_pkg::RQ_SRC +: 2];

  // ---------------------------------------------------------------
  // Plain-function map
  // ---------------------------------------------------------------
  always_comb begin
    plain[15] = (sel15 == pgpfc_pkg::SEL2_PLAIN);
    plain[14] = (sel14 == pgpfc_pkg::SEL2_PLAIN);
    plain[13] = ~st_q.selh[pgpfc_pkg::P13_SEL];
    plain[12] = ~st_q.selh[pgpfc_pkg::P12_SEL];
    plain[11] = ~st_q.selh[pgpfc_pkg::P11_SEL];
    plain[10] = ~st_q.selh[pgpfc_pkg::P10_SEL];
    plain[9]  = ~st_q.selh[pgpfc_pkg::P9_SEL];
    plain[8]  = ~st_q.selh[pgpfc_pkg::P8_SEL];
    plain[7]  = ~st_q.sell[pgpfc_pkg::P7_SEL];
    plain[6]  = ~st_q.sell[pgpfc_pkg::P6_SEL];
    plain[5]  = ~st_q.sell[pgpfc_pkg::P5_SEL];
    plain[4]  = ~st_q.sell[pgpfc_pkg::P4_SEL];
    plain[3]  = ~st_q.sell[pgpfc_pkg::P3_SEL];
    plain[2]  = ~st_q.sell[pgpfc_pkg::P2_SEL];
    plain[1]  = ~st_q.sell[pgpfc_pkg::P1_SEL];
    plain[0]  = (sel0 == pgpfc_pkg::SEL2_PLAIN);
  end

  // Request output: idle high, low while a chosen source requests
  always_comb begin
    unique case (rqsrc)
      2'h0:    request_output_pin = 1'b1;
      2'h1:    request_output_pin = ~interrupt_controller_request;
      2'h2:    request_output_pin = ~refresh_request;
      default: request_output_pin = ~(interrupt_controller_request | refresh_request);
    endcase
  end

  // ---------------------------------------------------------------
  // Pin drive
  // ---------------------------------------------------------------
  always_comb begin
    // Plain outputs drive the latch; direction 1 is output
    pin_out = st_q.latch;
    pin_oe  = st_q.dir & plain;
    // Timer channels, pins 15..9
    if (sel15 == pgpfc_pkg::SEL2_ALT2) begin
      pin_out[15] = timer_cc_out[0];
      pin_oe[15]  = timer_cc_oe[0];
    end
    if (sel14 == pgpfc_pkg::SEL2_ALT2) begin
      pin_out[14] = timer_cc_out[1];
      pin_oe[14]  = timer_cc_oe[1];
    end
    for (int i = 0; i < 5; i++) begin
      if (!plain[13-i]) begin
        pin_out[13-i] = timer_cc_out[2+i];
        pin_oe[13-i]  = timer_cc_oe[2+i];
      end
    end
    // Request inputs on 15/14 leave the pin undriven
    if (sel15 == pgpfc_pkg::SEL2_ALT1) begin
      pin_oe[15] = 1'b0;
    end
    if (sel14 == pgpfc_pkg::SEL2_ALT1) begin
      pin_oe[14] = 1'b0;
    end
    if (!plain[8]) begin
      pin_oe[8] = 1'b0;
    end
    if (!plain[7]) begin
      pin_out[7] = serial2_tx;
      pin_oe[7]  = 1'b1;
    end
    if (!plain[6]) begin
      pin_oe[6] = 1'b0;
    end
    if (!plain[5]) begin
      pin_out[5] = serial1_tx;
      pin_oe[5]  = 1'b1;
    end
    if (!plain[4]) begin
      pin_out[4] = serial1_clk_out;
      pin_oe[4]  = serial1_clk_oe;
    end
    if (!plain[3]) begin
      pin_oe[3] = 1'b0;
    end
    if (!plain[2]) begin
      pin_out[2] = serial0_tx;
      pin_oe[2]  = 1'b1;
    end
    if (!plain[1]) begin
      pin_out[1] = serial0_clk_out;
      pin_oe[1]  = serial0_clk_oe;
    end
    if (sel0 == pgpfc_pkg::SEL2_ALT1) begin
      pin_oe[0] = 1'b0;
    end else if (sel0 == pgpfc_pkg::SEL2_ALT2) begin
      pin_out[0] = request_output_pin;
      pin_oe[0]  = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Peripheral inputs
  // ---------------------------------------------------------------
  // Unselected serial, request and trigger inputs rest high; timer inputs rest low
  always_comb begin
    timer_cc_in[0]        = (sel15 == pgpfc_pkg::SEL2_ALT2) ? pin_s[15] : 1'b0;
    timer_cc_in[1]        = (sel14 == pgpfc_pkg::SEL2_ALT2) ? pin_s[14] : 1'b0;
    for (int i = 0; i < 5; i++) begin
      timer_cc_in[2+i] = plain[13-i] ? 1'b0 : pin_s[13-i];
    end
    ext_interrupt_in_5    = (sel15 == pgpfc_pkg::SEL2_ALT1) ? pin_s[15] : 1'b1;
    ext_interrupt_in_4    = (sel14 == pgpfc_pkg::SEL2_ALT1) ? pin_s[14] : 1'b1;
    serial2_rx            = plain[8] ? 1'b1 : pin_s[8];
    serial1_rx            = plain[6] ? 1'b1 : pin_s[6];
    serial1_clk_in        = plain[4] ? 1'b1 : pin_s[4];
    serial0_rx            = plain[3] ? 1'b1 : pin_s[3];
    serial0_clk_in        = plain[1] ? 1'b1 : pin_s[1];
    conversion_trigger_in = (sel0 == pgpfc_pkg::SEL2_ALT1) ? pin_s[0] : 1'b1;
  end

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  assign selh_rd = st_q.selh | pgpfc_pkg::SELH_ONES;
  assign sell_rd = st_q.sell | pgpfc_pkg::SELL_ONES;
  // Latch reads back only for plain outputs, pin state otherwise
  assign port_rd = (st_q.latch & st_q.dir & plain) | (pin_s & ~(st_q.dir & plain));

  always_comb begin
    st_d = st_q;
    if (bus.wr) begin
      unique case (bus.addr)
        pgpfc_pkg::ADDR_LATCH: st_d.latch = bus.wdata;
        pgpfc_pkg::ADDR_DIR:   st_d.dir   = bus.wdata;
        pgpfc_pkg::ADDR_SELH:  st_d.selh  = masked_write(st_q.selh, bus.wdata, pgpfc_pkg::SELH_WMASK);
        pgpfc_pkg::ADDR_SELL:  st_d.sell  = masked_write(st_q.sell, bus.wdata, pgpfc_pkg::SELL_WMASK);
        default: ;
      endcase
    end
    st_d.rdata = pgpfc_pkg::RESET_ZERO;
    if (bus.rd) begin
      unique case (bus.addr)
        pgpfc_pkg::ADDR_LATCH: st_d.rdata = port_rd;
        pgpfc_pkg::ADDR_DIR:   st_d.rdata = st_q.dir;
        pgpfc_pkg::ADDR_SELH:  st_d.rdata = selh_rd;
        pgpfc_pkg::ADDR_SELL:  st_d.rdata = sell_rd;
        default:               st_d.rdata = pgpfc_pkg::RESET_ZERO;
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_q.latch <= pgpfc_pkg::RESET_ZERO;
      st_q.dir   <= pgpfc_pkg::RESET_ZERO;
      st_q.selh  <= pgpfc_pkg::RESET_ZERO;
      st_q.sell  <= pgpfc_pkg::RESET_ZERO;
      st_q.rdata <= pgpfc_pkg::RESET_ZERO;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata = st_q.rdata;

endmodule : pgpfc_top
`default_nettype wire

// ===== tb/pgpfc_periph.sv
`timescale 1ns/100ps
`default_nettype none
module pgpfc_periph (
  // Clock and pacing
  input  wire logic clock,
  input  wire logic hold,
  // Peripheral outputs
  output logic [6:0] timer_cc_out,
  output logic [6:0] timer_cc_oe,
  output logic       serial2_tx,
  output logic       serial1_tx,
  output logic       serial1_clk_out,
  output logic       serial1_clk_oe,
  output logic       serial0_tx,
  output logic       serial0_clk_out,
  output logic       serial0_clk_oe,
  output logic       interrupt_controller_request,
  output logic       refresh_request
);
  // Hold freezes the pattern so synced pin levels can settle
  logic [31:0] s_q = 32'h1357_9bdf;
  always @(posedge clock) begin
    if (!hold) s_q <= {s_q[30:0], s_q[31] ^ s_q[21] ^ s_q[1] ^ s_q[0]};
  end
  assign {timer_cc_out, timer_cc_oe, serial2_tx, serial1_tx, serial1_clk_out, serial1_clk_oe, serial0_tx,
    serial0_clk_out, serial0_clk_oe, interrupt_controller_request, refresh_request} = s_q[22:0];
endmodule : pgpfc_periph
`default_nettype wire

// ===== tb/pgpfc_props.sv
`timescale 1ns/100ps
`default_nettype none
module pgpfc_props (
  // Clock and reset
  input wire logic                  clock,
  input wire logic                  reset_n,
  // Register port and pins
  input wire pgpfc_pkg::pgpfc_bus_s bus,
  input wire logic [15:0]           rdata,
  input wire logic [15:0]           pin_out,
  input wire logic [15:0]           pin_oe,
  // Peripheral side
  input wire logic [6:0]            timer_cc_in,
  input wire logic                  ext_interrupt_in_5,
  input wire logic                  serial2_tx,
  input wire logic                  interrupt_controller_request,
  input wire logic                  refresh_request
);
  // ---------------------------------------------------------------
  // Shadow of writable bits
  // ---------------------------------------------------------------
  logic [15:0] dir_q;
  logic [15:0] selh_q;
  logic [15:0] sell_q;
  logic        rd_q;
  logic [31:0] ra_q;
  logic        mapped;
  logic        req_x;
  assign mapped = ra_q inside {pgpfc_pkg::ADDR_LATCH, pgpfc_pkg::ADDR_DIR, pgpfc_pkg::ADDR_SELH, pgpfc_pkg::ADDR_SELL};
  assign req_x = (sell_q[0] & interrupt_controller_request) | (sell_q[1] & refresh_request);
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      dir_q  <= 16'h0000;
      selh_q <= 16'h0000;
      sell_q <= 16'h0000;
      rd_q   <= 1'b0;
      ra_q   <= 32'h0000_0000;
    end else begin
      rd_q <= bus.rd;
      ra_q <= bus.addr;
      if (bus.wr && bus.addr == pgpfc_pkg::ADDR_DIR) dir_q <= bus.wdata;
      if (bus.wr && bus.addr == pgpfc_pkg::ADDR_SELH) selh_q <= bus.wdata & pgpfc_pkg::SELH_WMASK;
      if (bus.wr && bus.addr == pgpfc_pkg::ADDR_SELL) sell_q <= bus.wdata & pgpfc_pkg::SELL_WMASK;
    end
  end
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  a_dir_read: assert property (rd_q && ra_q == pgpfc_pkg::ADDR_DIR |-> rdata == dir_q)
    else $error("direction readback wrong");
  a_selh_read: assert property (rd_q && ra_q == pgpfc_pkg::ADDR_SELH |-> rdata == (selh_q | 16'h0aaa))
    else $error("select high readback wrong");
  a_sell_read: assert property (rd_q && ra_q == pgpfc_pkg::ADDR_SELL |-> rdata == (sell_q | 16'haa80))
    else $error("select low readback wrong");
  a_rdata_zero: assert property (!(rd_q && mapped) |-> rdata == 16'h0000)
    else $error("read data not zero");
  a_reset_clear: assert property ($rose(reset_n) |-> pin_oe == 16'h0000 && rdata == 16'h0000)
    else $error("pins driven after reset");
  a_plain_oe: assert property (selh_q == 16'h0000 |-> pin_oe[15:8] == dir_q[15:8])
    else $error("plain pin enable wrong");
  a_tx_drive: assert property (bus.wr && bus.addr == pgpfc_pkg::ADDR_SELL && bus.wdata[14]
    |=> pin_oe[7] && pin_out[7] == serial2_tx)
    else $error("transmit pin not driven");
  a_req_out: assert property (sell_q[3:2] == 2'h2 |-> pin_oe[0] && pin_out[0] == !req_x)
    else $error("request output wrong");
  a_pin15_excl: assert property (!ext_interrupt_in_5 |-> !timer_cc_in[0])
    else $error("pin 15 two functions");
endmodule : pgpfc_props
bind pgpfc_top pgpfc_props pgpfc_props_i (.clock, .reset_n, .bus, .rdata, .pin_out, .pin_oe, .timer_cc_in,
  .ext_interrupt_in_5, .serial2_tx, .interrupt_controller_request, .refresh_request);
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic                  clock = 1'b0;
  logic                  reset_n = 1'b0;
  logic                  hold = 1'b1;
  pgpfc_pkg::pgpfc_bus_s bus = '0;
  logic [15:0]           ext = 16'h0000;
  logic [15:0]           d;
  logic [15:0]           e;
  logic [31:0]           rs = 32'he78c_d0f3;
  int                    n_errors = 0;
  int                    num_checks = 0;
  // Latch, direction, select high, select low, unmapped
  logic [31:0] am [5] = '{pgpfc_pkg::ADDR_LATCH, pgpfc_pkg::ADDR_DIR, pgpfc_pkg::ADDR_SELH, pgpfc_pkg::ADDR_SELL,
    32'hffff_83b6};
  wire logic [15:0] rdata, pin_in, pin_out, pin_oe;
  wire logic [6:0]  timer_cc_out, timer_cc_oe, timer_cc_in;
  wire logic ext_interrupt_in_5, ext_interrupt_in_4, serial2_rx, serial2_tx, serial1_rx, serial1_tx;
  wire logic serial1_clk_out, serial1_clk_oe, serial1_clk_in, serial0_rx, serial0_tx, serial0_clk_out;
  wire logic serial0_clk_oe, serial0_clk_in, conversion_trigger_in, interrupt_controller_request, refresh_request;
  always #5 clock = ~clock;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
  pgpfc_top pgpfc_top_i (.clock, .reset_n, .bus, .rdata, .pin_in, .pin_out, .pin_oe, .timer_cc_out,
    .timer_cc_oe, .timer_cc_in, .ext_interrupt_in_5, .ext_interrupt_in_4, .serial2_rx, .serial2_tx, .serial1_rx,
    .serial1_tx, .serial1_clk_out, .serial1_clk_oe, .serial1_clk_in, .serial0_rx, .serial0_tx, .serial0_clk_out,
    .serial0_clk_oe, .serial0_clk_in, .conversion_trigger_in, .interrupt_controller_request, .refresh_request);
  pgpfc_periph pgpfc_periph_i (.clock, .hold, .timer_cc_out, .timer_cc_oe, .serial2_tx, .serial1_tx,
    .serial1_clk_out, .serial1_clk_oe, .serial0_tx, .serial0_clk_out, .serial0_clk_oe, .interrupt_controller_request,
    .refresh_request);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  function automatic logic req_level(input logic [1:0] src, input logic i, input logic r);
    return !((src[0] && i) || (src[1] && r));
  endfunction : req_level
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] x);
    num_checks++;
    if (seen !== x) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, x, seen);
    end
  endtask : chk
  task automatic wr(input int j, input logic [15:0] v);
    @(posedge clock);
    bus.addr <= am[j];
    bus.wdata <= v;
    bus.wr <= 1'b1;
    @(posedge clock);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(input int j, input logic [15:0] x, input string nm);
    @(posedge clock);
    bus.addr <= am[j];
    bus.rd <= 1'b1;
    @(posedge clock);
    bus.rd <= 1'b0;
    #1;
    chk(nm, rdata, x);
  endtask : rd
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  // Whole run is under 2000 cycles; ten times that is a hang
  initial begin
    #200_000;
    n_errors++;
    conclude();
  end
  initial begin
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    rd(1, 16'h0000, "dir");
    rd(2, 16'h0aaa, "selh");
    rd(3, 16'haa80, "sell");
    wr(4, 16'hffff);
    rd(4, 16'h0000, "unmapped");
    #30;
    chk("idle", {ext_interrupt_in_5, ext_interrupt_in_4, serial2_rx, serial1_rx, serial1_clk_in, serial0_rx,
      serial0_clk_in, conversion_trigger_in, timer_cc_in}, {8'hff, 7'h00});
    $display("test reset done");
    for (int i = 0; i < 24; i++) begin
      rs = xs(rs);
      d = rs[15:0] & 16'hf555;
      d[14] = d[14] & !d[15];
      d[12] = d[12] & !d[13];
      e = rs[31:16] & 16'h557f;
      e[2] = e[2] & !e[3];
      wr(2, d);
      rd(2, d | 16'h0aaa, "selh");
      wr(3, e);
      rd(3, e | 16'haa80, "sell");
      wr(1, rs[23:8]);
      rd(1, rs[23:8], "dir");
    end
    wr(2, 16'h0000);
    wr(3, 16'h0000);
    $display("test registers done");
    for (int i = 0; i < 16; i++) begin
      rs = xs(rs);
      d = rs[31:16] ^ rs[15:0];
      e = rs[15:0];
      @(posedge clock);
      ext <= rs[31:16];
      wr(1, e);
      wr(0, d);
      #30;
      chk("oe", pin_oe, e);
      chk("out", pin_out & e, d & e);
      rd(0, (d & e) | (rs[31:16] & ~e), "latch");
    end
    $display("test plain done");
    for (int k = 0; k < 5; k++) begin
      rs = xs(rs);
      d = (k == 0) ? 16'h9555 : 16'h6555;
      e = (k == 0) ? 16'h5575 : 16'h5578 | 16'(k - 1);
      @(posedge clock);
      hold <= 1'b0;
      ext <= rs[15:0];
      wr(2, d);
      wr(3, e);
      @(posedge clock);
      hold <= 1'b1;
      #30;
      chk("tx", {pin_out[7], pin_out[5], pin_out[2], pin_oe[7], pin_oe[5], pin_oe[2]},
        {serial2_tx, serial1_tx, serial0_tx, 3'h7});
      chk("sclk", {pin_out[4], pin_oe[4], pin_out[1], pin_oe[1]},
        {serial1_clk_out, serial1_clk_oe, serial0_clk_out, serial0_clk_oe});
      chk("rx", {serial2_rx, serial1_rx, serial1_clk_in, serial0_rx, serial0_clk_in},
        {pin_in[8], pin_in[6], pin_in[4], pin_in[3], pin_in[1]});
      chk("tmr", {timer_cc_in[6:2], pin_oe[13:9]}, {pin_in[9], pin_in[10], pin_in[11], pin_in[12], pin_in[13],
        timer_cc_oe[2], timer_cc_oe[3], timer_cc_oe[4], timer_cc_oe[5], timer_cc_oe[6]});
      chk("hi", {ext_interrupt_in_5, ext_interrupt_in_4, timer_cc_in[1:0]}, (k == 0) ?
        {1'b1, pin_in[14], 1'b0, pin_in[15]} : {pin_in[15], 1'b1, pin_in[14], 1'b0});
      chk("p0", {conversion_trigger_in, pin_oe[0], pin_out[0] & pin_oe[0]}, (k == 0) ? {pin_in[0], 2'b00} :
        {2'b11, req_level(e[1:0], interrupt_controller_request, refresh_request)});
    end
    $display("test functions done");
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    rd(3, 16'haa80, "sell");
    $display("test second reset done");
    conclude();
  end
endmodule : tb
`default_nettype wire
